// ---- rtl/spc_map.svh ----
// Constants of the standalone phrase playback controller: timing, offsets, reset values
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Clock rate in hertz
`define SPC_CLK_HZ 100000000
// Settle time on the low phrase select inputs, in milliseconds
`define SPC_DEBOUNCE_MS 16
// Delay from phrase end to standby, in seconds
`define SPC_STANDBY_AFTER_VOICE_DELAY_S 0.2

// Register byte addresses
`define SPC_ADDR_CTRL 12'h000
`define SPC_ADDR_LEN 12'h004
`define SPC_ADDR_STAT 12'h008

// Register select codes
`define SPC_SEL_CTRL 2'h0
`define SPC_SEL_LEN 2'h1
`define SPC_SEL_STAT 2'h2
`define SPC_SEL_NONE 2'h3

// Control register fields and reset values
`define SPC_CTRL_STANDBY_AFTER_VOICE_BIT 0
`define SPC_CTRL_RND_BIT 1
`define SPC_CTRL_W 2
`define SPC_CTRL_RST 2'h1
`define SPC_LEN_RST 32'h00000100

// Status register field positions
`define SPC_STAT_MODE_LSB 0
`define SPC_STAT_BUSY_BIT 4
`define SPC_STAT_PHR_LSB 8
`define SPC_STAT_TEST_BIT 16
`define SPC_STAT_CSEL_BIT 17
`define SPC_STAT_DEB_BIT 18

// Pin defaults {clk_sel, test_n, rnd_n, high, low}: pulled-up pins high, pulled-down low
`define SPC_PINS_RST 10'h180
`define SPC_LFSR_SEED 7'h01

// Audio output modes
`define SPC_AUDIO_GND 2'h0
`define SPC_AUDIO_MID 2'h1
`define SPC_AUDIO_LIVE 2'h2

`endif

// ---- rtl/spc_pkg.sv ----
// Types of the standalone phrase playback controller
package spc_pkg;

    // Synchronised pin group
    typedef struct packed {
        logic clk_sel;
        logic test_n;
        logic rnd_n;
        logic [2:0] high;
        logic [3:0] low;
    } spc_pins_t;

    // Operating modes, one-hot
    typedef enum logic [3:0] {
        ST_STANDBY_AFTER_VOICE = 4'h1,
        ST_IDLE = 4'h2,
        ST_PLAY = 4'h4,
        ST_HOLD = 4'h8
    } spc_mode_t;

    // Whole state of the controller
    typedef struct packed {
        spc_mode_t mode;
        spc_pins_t s1;
        spc_pins_t s2;
        spc_pins_t s3;
        spc_pins_t filt;
        logic deb_on;
        logic [31:0] deb_cnt;
        logic [31:0] cnt;
        logic [6:0] lfsr;
        logic [6:0] phrase;
        logic [1:0] ctrl;
        logic [31:0] play_len;
        logic busy_n;
        logic osc_run;
        logic osc_second;
        logic osc_third;
        logic [1:0] audio;
        logic play_pulse;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spc_regs_t;

endpackage

// ---- rtl/spc_top.sv ----
// Standalone phrase playback controller with APB register access
//
// Function
// - Reset low forces standby, stops oscillator, grounds audio, loads reset values into all state.
// - Busy output low throughout playback, high otherwise from power-on.
// - Second oscillator pin driven low in standby.
// - Third oscillator pin driven high in standby when RC selected.
// - Random request falling edge fetches random phrase address and plays it.
// - Low select change starts 16 ms wait, then capture and play of a nonzero phrase.
// - Lowest high select bit ignored while random play enabled.
// - Low selects default low; reset, random, test inputs default high.
// - Standby 0.2 s after phrase when enabled, else audio held at mid-supply.
`timescale 1ns/10ps
`include "spc_map.svh"

module spc_top #(
    parameter int DEBOUNCE_CYC = `SPC_DEBOUNCE_MS * (`SPC_CLK_HZ / 1000),
    parameter int STANDBY_AFTER_VOICE_CYC = int'(`SPC_STANDBY_AFTER_VOICE_DELAY_S * `SPC_CLK_HZ)
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLOCK_SOURCE_SELECT_I,
    input wire logic TEST_N_I,
    input wire logic RANDOM_PLAY_REQUEST_N_I,
    input wire logic [2:0] PHRASE_SELECT_HIGH_I,
    input wire logic [3:0] PHRASE_SELECT_LOW_I,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic BUSY_N_O,
    output logic OSC_RUN_O,
    output logic OSCILLATOR_OUT_SECOND_O,
    output logic OSCILLATOR_OUT_THIRD_O,
    output logic [1:0] AUDIO_OUTPUT_MODE_O,
    output logic [6:0] PHRASE_O,
    output logic PLAY_START_O
);

    localparam logic [31:0] DEB_LAST = 32'(DEBOUNCE_CYC - 1);
    localparam logic [31:0] STANDBY_AFTER_VOICE_LAST = 32'(STANDBY_AFTER_VOICE_CYC - 1);

    // Everything starts in standby with pins at their pulled levels
    localparam spc_pkg::spc_regs_t RST_VAL = '{
        mode: spc_pkg::ST_STANDBY_AFTER_VOICE,
        s1: `SPC_PINS_RST,
        s2: `SPC_PINS_RST,
        s3: `SPC_PINS_RST,
        filt: `SPC_PINS_RST,
        lfsr: `SPC_LFSR_SEED,
        ctrl: `SPC_CTRL_RST,
        play_len: `SPC_LEN_RST,
        busy_n: 1'b1,
        osc_third: 1'b1,
        audio: `SPC_AUDIO_GND,
        default: '0
    };

    spc_pkg::spc_regs_t q;
    spc_pkg::spc_regs_t d;
    spc_pkg::spc_pins_t pins_in;
    spc_pkg::spc_pins_t agree;
    logic rnd_fall;
    logic low_chg;
    logic start;
    logic [6:0] phr;
    logic [1:0] sel;
    logic acc;

    // Register select from a bus address, shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        logic [1:0] s;
        s = `SPC_SEL_NONE;
        if (a == `SPC_ADDR_CTRL) begin
            s = `SPC_SEL_CTRL;
        end else if (a == `SPC_ADDR_LEN) begin
            s = `SPC_SEL_LEN;
        end else if (a == `SPC_ADDR_STAT) begin
            s = `SPC_SEL_STAT;
        end
        return s;
    endfunction

    // Phrase number from the select pins, lowest low select as bit 0
    function automatic logic [6:0] phrase_of(input spc_pkg::spc_pins_t p, input logic rnd_en);
        logic [2:0] h;
        h = p.high;
        if (rnd_en) begin
            h[0] = 1'b0;
        end
        return {h, p.low};
    endfunction

    assign pins_in = {CLOCK_SOURCE_SELECT_I, TEST_N_I, RANDOM_PLAY_REQUEST_N_I,
                      PHRASE_SELECT_HIGH_I, PHRASE_SELECT_LOW_I};
    assign acc = PSEL & PENABLE;
    assign sel = reg_sel(PADDR);

    // Next-state logic for the whole controller
    always_comb begin
        d = q;
        agree = '0;
        rnd_fall = 1'b0;
        low_chg = 1'b0;
        start = 1'b0;
        phr = q.phrase;
        // Three-stage synchroniser; a bit is taken once stages two and three agree
        d.s1 = pins_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.filt = (q.s3 & agree) | (q.filt & ~agree);
        // Free-running random address source, never zero
        d.lfsr = {q.lfsr[5:0], q.lfsr[6] ^ q.lfsr[5]};
        rnd_fall = q.filt.rnd_n & ~d.filt.rnd_n;
        low_chg = d.filt.low != q.filt.low;
        d.play_pulse = 1'b0;
        // Each new change restarts the settle wait, so bouncing switches play once
        if (low_chg) begin
            d.deb_on = 1'b1;
            d.deb_cnt = DEB_LAST;
        end else if (q.deb_on) begin
            if (q.deb_cnt == 32'h00000000) begin
                d.deb_on = 1'b0;
                phr = phrase_of(q.filt, q.ctrl[`SPC_CTRL_RND_BIT]);
                start = phr != 7'h00;
            end else begin
                d.deb_cnt = q.deb_cnt - 32'h00000001;
            end
        end
        // A random request wins over a settled switch in the same cycle
        if (rnd_fall) begin
            phr = q.lfsr;
            start = 1'b1;
        end
        // Playback sequencing
        if (start) begin
            d.phrase = phr;
            d.mode = spc_pkg::ST_PLAY;
            d.cnt = q.play_len;
            d.play_pulse = 1'b1;
        end else begin
            case (q.mode)
                spc_pkg::ST_PLAY: begin
                    if (q.cnt == 32'h00000000) begin
                        if (q.ctrl[`SPC_CTRL_STANDBY_AFTER_VOICE_BIT]) begin
                            d.mode = spc_pkg::ST_HOLD;
                            d.cnt = STANDBY_AFTER_VOICE_LAST;
                        end else begin
                            d.mode = spc_pkg::ST_IDLE;
                        end
                    end else begin
                        d.cnt = q.cnt - 32'h00000001;
                    end
                end
                spc_pkg::ST_HOLD: begin
                    if (q.cnt == 32'h00000000) begin
                        d.mode = spc_pkg::ST_STANDBY_AFTER_VOICE;
                    end else begin
                        d.cnt = q.cnt - 32'h00000001;
                    end
                end
                default: begin
                    d.mode = q.mode;
                end
            endcase
        end
        // Pin and audio outputs follow the next mode so they change with it
        d.busy_n = d.mode != spc_pkg::ST_PLAY;
        d.osc_run = d.mode != spc_pkg::ST_STANDBY_AFTER_VOICE;
        d.osc_second = d.osc_run & ~q.osc_second;
        d.osc_third = d.osc_run ? (~d.filt.clk_sel & q.osc_second) : ~d.filt.clk_sel;
        case (d.mode)
            spc_pkg::ST_PLAY: d.audio = `SPC_AUDIO_LIVE;
            spc_pkg::ST_STANDBY_AFTER_VOICE: d.audio = `SPC_AUDIO_GND;
            default: d.audio = `SPC_AUDIO_MID;
        endcase
        // APB slave: one wait state, answer in the second access cycle
        d.pready = acc & ~q.pready;
        d.pslverr = 1'b0;
        if (acc & ~q.pready) begin
            d.pslverr = sel == `SPC_SEL_NONE;
            case (sel)
                `SPC_SEL_CTRL: d.prdata = {30'h00000000, q.ctrl};
                `SPC_SEL_LEN: d.prdata = q.play_len;
                `SPC_SEL_STAT: begin
                    d.prdata = 32'h00000000;
                    d.prdata[`SPC_STAT_MODE_LSB +: 4] = q.mode;
                    d.prdata[`SPC_STAT_BUSY_BIT] = q.busy_n;
                    d.prdata[`SPC_STAT_PHR_LSB +: 7] = q.phrase;
                    d.prdata[`SPC_STAT_TEST_BIT] = q.filt.test_n;
                    d.prdata[`SPC_STAT_CSEL_BIT] = q.filt.clk_sel;
                    d.prdata[`SPC_STAT_DEB_BIT] = q.deb_on;
                end
                default: d.prdata = 32'h00000000;
            endcase
        end
        // Writes land only at the completing edge
        if (acc & q.pready & PWRITE) begin
            if (sel == `SPC_SEL_CTRL) begin
                d.ctrl = PWDATA[`SPC_CTRL_W-1:0];
            end else if (sel == `SPC_SEL_LEN) begin
                d.play_len = PWDATA;
            end
        end
    end

    // State register; reset puts everything back to standby
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state flip-flops
    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign BUSY_N_O = q.busy_n;
    assign OSC_RUN_O = q.osc_run;
    assign OSCILLATOR_OUT_SECOND_O = q.osc_second;
    assign OSCILLATOR_OUT_THIRD_O = q.osc_third;
    assign AUDIO_OUTPUT_MODE_O = q.audio;
    assign PHRASE_O = q.phrase;
    assign PLAY_START_O = q.play_pulse;

endmodule

// ---- sim/spc_checker.sv ----
// Port assertions for the phrase playback controller
`timescale 1ns/10ps
module spc_checker (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLOCK_SOURCE_SELECT_I,
    input wire logic RANDOM_PLAY_REQUEST_N_I,
    input wire logic [3:0] PHRASE_SELECT_LOW_I,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic BUSY_N_O,
    input wire logic OSC_RUN_O,
    input wire logic OSCILLATOR_OUT_SECOND_O,
    input wire logic OSCILLATOR_OUT_THIRD_O,
    input wire logic [1:0] AUDIO_OUTPUT_MODE_O,
    input wire logic [6:0] PHRASE_O,
    input wire logic PLAY_START_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Start as seen on the pins: pulse and busy together
    sequence s_start;
        PLAY_START_O ##0 !BUSY_N_O;
    endsequence
    // Strap held at RC long enough to clear the synchroniser
    sequence s_rc_standby_after_voice;
        (!CLOCK_SOURCE_SELECT_I) [*6] ##0 !OSC_RUN_O;
    endsequence
    a_start_live: assert property (s_start |-> AUDIO_OUTPUT_MODE_O == 2'h2 && PHRASE_O != 7'h00)
        else $error("start without live audio or phrase");
    a_busy_audio: assert property (!BUSY_N_O |-> AUDIO_OUTPUT_MODE_O == 2'h2)
        else $error("busy while audio not live");
    a_standby_after_voice_ground: assert property (!OSC_RUN_O |-> AUDIO_OUTPUT_MODE_O == 2'h0 && !OSCILLATOR_OUT_SECOND_O)
        else $error("standby without ground or low osc pin");
    a_rc_oscillator_out_third: assert property (s_rc_standby_after_voice |-> OSCILLATOR_OUT_THIRD_O)
        else $error("third osc pin low in rc standby");
    a_reset_init: assert property ($rose(RESET_N_I) |-> BUSY_N_O && !OSC_RUN_O && PHRASE_O == 7'h00)
        else $error("state not initialised after reset");
    a_rnd_start: assert property ($fell(RANDOM_PLAY_REQUEST_N_I) |-> ##[1:8] PLAY_START_O)
        else $error("random request did not start play");
    a_sw_settle: assert property ($changed(PHRASE_SELECT_LOW_I) |=> !PLAY_START_O [*8])
        else $error("switch start before settle time");
    a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("apb access not answered after one wait");
endmodule

// ---- sim/spc_switches.sv ----
// Switch panel and strap logic driving the controller pins
`timescale 1ns/10ps
module spc_switches (
    input wire logic clk_i,
    output logic clk_sel_o,
    output logic test_n_o,
    output logic rnd_n_o,
    output logic [2:0] high_o,
    output logic [3:0] low_o,
    output logic prog_supply_o,
    output logic program_tool_link_o,
    output logic host_mode_o
);
    // Straps fixed for RC clocking and normal operation
    initial begin
        clk_sel_o = 1'b0;
        test_n_o = 1'b1;
        rnd_n_o = 1'b1;
        high_o = 3'h0;
        low_o = 4'h0;
        // Programming pins idle and host strap at standalone; the block has no such pins
        prog_supply_o = 1'b1;
        program_tool_link_o = 1'b0;
        host_mode_o = 1'b0;
    end
    // Contacts move just after an edge, never on it
    task set_phrase(input logic [2:0] h, input logic [3:0] l);
        @(posedge clk_i);
        high_o <= h;
        low_o <= l;
    endtask
    // Random button; callers return it high when done
    task set_random(input logic lvl);
        @(posedge clk_i);
        rnd_n_o <= lvl;
    endtask
endmodule

// ---- sim/spc_top_test.sv ----
// Self-checking bench for the phrase playback controller
`timescale 1ns/10ps
module spc_top_test;
    localparam int DEB = 20;
    localparam int STB = 30;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, busy_n, osc_run, osc_second, osc_third, start, err;
    logic clk_sel, test_n, rnd_n;
    logic [2:0] high;
    logic [3:0] low;
    logic [1:0] audio;
    logic [6:0] phrase;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    // Clock and a hang guard sized well above the full run
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    spc_switches sw (.clk_i(clk), .clk_sel_o(clk_sel), .test_n_o(test_n), .rnd_n_o(rnd_n),
        .high_o(high), .low_o(low), .prog_supply_o(), .program_tool_link_o(), .host_mode_o());
    spc_top #(.DEBOUNCE_CYC(DEB), .STANDBY_AFTER_VOICE_CYC(STB)) dut (.CLK_I(clk), .RESET_N_I(rst_n),
        .CLOCK_SOURCE_SELECT_I(clk_sel), .TEST_N_I(test_n), .RANDOM_PLAY_REQUEST_N_I(rnd_n),
        .PHRASE_SELECT_HIGH_I(high), .PHRASE_SELECT_LOW_I(low), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BUSY_N_O(busy_n), .OSC_RUN_O(osc_run),
        .OSCILLATOR_OUT_SECOND_O(osc_second), .OSCILLATOR_OUT_THIRD_O(osc_third),
        .AUDIO_OUTPUT_MODE_O(audio), .PHRASE_O(phrase), .PLAY_START_O(start));
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer; the answer is taken at the rising edge that sees pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_start(input int lim);
        n = 0;
        while (start !== 1'b1 && n < lim) begin
            @(negedge clk);
            n = n + 1;
        end
    endtask
    task busy_len();
        n = 0;
        while (busy_n === 1'b0 && n < 50) begin
            @(negedge clk);
            n = n + 1;
        end
    endtask
    task t_reset();
        @(negedge clk);
        check("busy_n", 32'h1, busy_n);
        check("osc_run", 32'h0, osc_run);
        check("audio", 32'h0, audio);
        check("osc_second", 32'h0, osc_second);
        check("osc_third", 32'h1, osc_third);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl", 32'h1, rd);
        apb(1'b0, 12'h004, 32'h0);
        check("len", 32'h100, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        check("slverr", 32'h1, err);
        check("slv_data", 32'h0, rd);
        apb(1'b1, 12'h004, 32'h2);
        apb(1'b0, 12'h004, 32'h0);
        check("len_rw", 32'h2, rd);
    endtask
    task t_switch();
        apb(1'b1, 12'h000, 32'h0);
        sw.set_phrase(3'h1, 4'h5);
        @(negedge clk);
        wait_start(DEB + 20);
        check("settle", 32'h1, n >= DEB && n <= DEB + 8);
        check("phrase", 32'h15, phrase);
        busy_len();
        check("busy_len", 32'h3, n);
        check("audio_mid", 32'h1, audio);
        sw.set_phrase(3'h0, 4'h0);
        @(negedge clk);
        wait_start(DEB + 20);
        check("zero_idle", DEB + 20, n);
    endtask
    task t_random();
        apb(1'b1, 12'h000, 32'h2);
        sw.set_phrase(3'h3, 4'h1);
        @(negedge clk);
        wait_start(DEB + 20);
        check("high_lsb_masked", 32'h21, phrase);
        busy_len();
        sw.set_random(1'b0);
        wait_start(10);
        check("rnd_start", 32'h1, start);
        check("rnd_phrase", 32'h1, phrase != 7'h00);
        sw.set_random(1'b1);
        busy_len();
    endtask
    task t_standby();
        apb(1'b1, 12'h000, 32'h1);
        sw.set_phrase(3'h0, 4'h2);
        @(negedge clk);
        wait_start(DEB + 20);
        busy_len();
        check("hold_audio", 32'h1, audio);
        repeat (STB + 5) @(negedge clk);
        check("standby_after_voice_osc", 32'h0, osc_run);
        check("standby_after_voice_osc_third", 32'h1, osc_third);
        check("standby_after_voice_osc_second", 32'h0, osc_second);
        check("standby_after_voice_audio", 32'h0, audio);
        // Status: standby mode, not busy, phrase 2, test pin high, RC strap
        apb(1'b0, 12'h008, 32'h0);
        check("stat", 32'h00010211, rd);
    endtask
    // Reset in mid-play must drop everything back to standby and reset values
    task t_reset_mid();
        sw.set_phrase(3'h0, 4'h3);
        @(negedge clk);
        wait_start(DEB + 20);
        check("mid_play", 32'h0, busy_n);
        check("mid_phrase", 32'h3, phrase);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check("rst_busy", 32'h1, busy_n);
        check("rst_osc", 32'h0, osc_run);
        check("rst_audio", 32'h0, audio);
        check("rst_phrase", 32'h0, phrase);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        check("rst_len", 32'h100, rd);
    endtask
    task complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_switch();
        t_random();
        t_standby();
        t_reset_mid();
        complete_run();
    end
endmodule
bind spc_top spc_checker chk (.CLK_I, .RESET_N_I, .CLOCK_SOURCE_SELECT_I,
    .RANDOM_PLAY_REQUEST_N_I, .PHRASE_SELECT_LOW_I, .PSEL, .PENABLE, .PREADY, .BUSY_N_O,
    .OSC_RUN_O, .OSCILLATOR_OUT_SECOND_O, .OSCILLATOR_OUT_THIRD_O, .AUDIO_OUTPUT_MODE_O,
    .PHRASE_O, .PLAY_START_O);
